/* rtl/slr_regs.vh */
/*
 * Register map, field positions, reset values and timing counts of the
 * serial lane high-speed receive port.
 * Assumes a 20 MHz system clock and a 32-bit APB register bus.
 */
`ifndef SLR_REGS_VH
`define SLR_REGS_VH

////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define SLR_ADDR_CTRL       8'h00
`define SLR_ADDR_STATUS     8'h04
`define SLR_ADDR_INT_STAT   8'h08
`define SLR_ADDR_INT_EN     8'h0C
`define SLR_ADDR_INT_CLR    8'h10
`define SLR_ADDR_BYTE_CNT   8'h14

////////////////////////////////////////////////////////////////////////////
// Control fields
`define SLR_CTRL_ENABLE     0
`define SLR_CTRL_HIGH_RATE  1
`define SLR_CTRL_RESET      2'h0

// Live status fields
`define SLR_ST_CLK_PRESENT  0
`define SLR_ST_ULPS         1
`define SLR_ST_ACTIVE       2
`define SLR_ST_SKEW         3

// Interrupt event fields
`define SLR_EV_BURST_START  0
`define SLR_EV_BURST_END    1
`define SLR_EV_ULPS_ENTRY   2
`define SLR_EV_SKEW_SEEN    3
`define SLR_EV_CLK_LOST     4
`define SLR_EV_WIDTH        5
`define SLR_INT_EN_RESET    5'h00

////////////////////////////////////////////////////////////////////////////
// Line patterns and lane states
`define SLR_SYNC_BYTE       8'hB8
`define SLR_SKEW_BYTE       8'hFF
`define SLR_LP_STOP         2'h3
`define SLR_LP_ZERO         2'h0
`define SLR_LP_ULPS_REQ     2'h2

////////////////////////////////////////////////////////////////////////////
// Timing
`define SLR_CLK_PERIOD_NS   50
`define SLR_CLK_TIMEOUT_NS  2000
`define SLR_CLK_TIMEOUT_CYC (`SLR_CLK_TIMEOUT_NS / `SLR_CLK_PERIOD_NS)
`define SLR_CLK_IDLE_LAST   8'h27

`endif

/* rtl/slr_pin_sync.v */
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes the input is asynchronous to clk; output changes only when
 * the second and third stages agree.
 */
`timescale 1ns/1ns
`default_nettype none

module slr_pin_sync
(
    input  wire clk,
    input  wire rst,
    input  wire pinIn,
    output reg  pinOut
);

    reg stage1;
    reg stage2;
    reg stage3;

    always @(posedge clk)
    begin
        if (rst)
        begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            pinOut <= 1'b0;
        end
        else
        begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3)
            begin
                pinOut <= stage3;
            end
        end
    end

endmodule

`default_nettype wire

/* rtl/slr_lane_rx.v */
/*
 * High-speed receive protocol port of one serial lane: clock-lane status,
 * byte clock, byte stream, burst flags, APB registers and interrupt.
 * Assumes lane pins are sampled well above the lane bit rate and that
 * the protocol side samples outputs on rising edges of rxByteClk.
 */
`timescale 1ns/1ns
`default_nettype none
`include "slr_regs.vh"

module slr_lane_rx
(
    input  wire        clk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        laneClkPin,
    input  wire        laneBitPin,
    input  wire [1:0]  clkLaneLpPin,
    input  wire [1:0]  dataLaneLpPin,
    output reg         clock_lane_clock_present,
    output reg         clock_lane_ultra_low_power_n,
    output reg         rxByteClk,
    output reg  [7:0]  rxData,
    output reg         rxValid,
    output reg         rxActive,
    output reg         rxSyncSeen,
    output reg         rxSkewCal,
    output reg         irq
);

    localparam [4:0] ST_IDLE  = 5'h01;
    localparam [4:0] ST_HUNT  = 5'h02;
    localparam [4:0] ST_DATA  = 5'h04;
    localparam [4:0] ST_SKEW  = 5'h08;
    localparam [4:0] ST_FLUSH = 5'h10;

    wire       lineClk;
    wire       lineBit;
    wire [1:0] clkLp;
    wire [1:0] dataLp;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    slr_pin_sync syncClk
    (
        .clk    (clk),
        .rst    (rst),
        .pinIn  (laneClkPin),
        .pinOut (lineClk)
    );

    slr_pin_sync syncBit
    (
        .clk    (clk),
        .rst    (rst),
        .pinIn  (laneBitPin),
        .pinOut (lineBit)
    );

    slr_pin_sync syncClkLp0
    (
        .clk    (clk),
        .rst    (rst),
        .pinIn  (clkLaneLpPin[0]),
        .pinOut (clkLp[0])
    );

    slr_pin_sync syncClkLp1
    (
        .clk    (clk),
        .rst    (rst),
        .pinIn  (clkLaneLpPin[1]),
        .pinOut (clkLp[1])
    );

    slr_pin_sync syncDataLp0
    (
        .clk    (clk),
        .rst    (rst),
        .pinIn  (dataLaneLpPin[0]),
        .pinOut (dataLp[0])
    );

    slr_pin_sync syncDataLp1
    (
        .clk    (clk),
        .rst    (rst),
        .pinIn  (dataLaneLpPin[1]),
        .pinOut (dataLp[1])
    );

    ////////////////////////////////////////////////////////////////////////
    // Registers and state
    reg  [1:0]               ctrl;
    reg  [`SLR_EV_WIDTH-1:0] intStat;
    reg  [`SLR_EV_WIDTH-1:0] intEn;
    reg  [15:0]              byteCnt;
    reg  [15:0]              burstCnt;
    reg                      lineClkLast;
    reg  [7:0]               idleCnt;
    reg                      ulpsArmed;
    reg  [4:0]               state;
    reg  [2:0]               bitCnt;
    reg  [7:0]               shiftReg;
    reg  [7:0]               heldByte;
    reg                      heldValid;
    reg                      startPending;
    reg  [1:0]               flushCnt;

    wire       bitStb    = lineClk != lineClkLast;
    wire [7:0] nextShift = {lineBit, shiftReg[7:1]};
    wire       enable    = ctrl[`SLR_CTRL_ENABLE];
    wire       highRate  = ctrl[`SLR_CTRL_HIGH_RATE];
    wire       laneStop  = dataLp == `SLR_LP_STOP;
    wire       apbSetup  = psel & ~penable;
    wire       apbWrite  = psel & penable & pready & pwrite;

    reg  [`SLR_EV_WIDTH-1:0] evNow;
    reg  [31:0]              next_prdata;
    reg                      next_pslverr;

    ////////////////////////////////////////////////////////////////////////
    // Clock-lane status
    always @(posedge clk)
    begin
        if (rst)
        begin
            lineClkLast                  <= 1'b0;
            idleCnt                      <= 8'h00;
            clock_lane_clock_present     <= 1'b0;
            clock_lane_ultra_low_power_n <= 1'b1;
            ulpsArmed                    <= 1'b0;
        end
        else
        begin
            lineClkLast <= lineClk;
            if (bitStb)
            begin
                idleCnt                  <= 8'h00;
                clock_lane_clock_present <= 1'b1;
            end
            else if (idleCnt == `SLR_CLK_IDLE_LAST)
            begin
                clock_lane_clock_present <= 1'b0;
            end
            else
            begin
                idleCnt <= idleCnt + 8'h01;
            end
            if (clkLp == `SLR_LP_ULPS_REQ)
            begin
                ulpsArmed <= 1'b1;
            end
            else if (clkLp != `SLR_LP_ZERO)
            begin
                ulpsArmed <= 1'b0;
            end
            if (ulpsArmed && clkLp == `SLR_LP_ZERO)
            begin
                clock_lane_ultra_low_power_n <= 1'b0;
            end
            else if (clkLp == `SLR_LP_STOP)
            begin
                clock_lane_ultra_low_power_n <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data-lane receiver
    always @(posedge clk)
    begin
        if (rst)
        begin
            state        <= ST_IDLE;
            bitCnt       <= 3'h0;
            shiftReg     <= 8'h00;
            heldByte     <= 8'h00;
            heldValid    <= 1'b0;
            startPending <= 1'b0;
            flushCnt     <= 2'h0;
            rxByteClk    <= 1'b0;
            rxData       <= 8'h00;
            rxValid      <= 1'b0;
            rxActive     <= 1'b0;
            rxSyncSeen   <= 1'b0;
            rxSkewCal    <= 1'b0;
            burstCnt     <= 16'h0000;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    shiftReg <= 8'h00;
                    if (enable && dataLp == `SLR_LP_ZERO)
                    begin
                        state <= ST_HUNT;
                    end
                end
                ST_HUNT:
                begin
                    if (laneStop)
                    begin
                        state <= ST_IDLE;
                    end
                    else if (bitStb)
                    begin
                        shiftReg <= nextShift;
                        if (nextShift == `SLR_SYNC_BYTE)
                        begin
                            state        <= ST_DATA;
                            bitCnt       <= 3'h0;
                            startPending <= 1'b1;
                            burstCnt     <= 16'h0000;
                            rxByteClk    <= 1'b1;
                        end
                        else if (highRate &&
                                 nextShift == `SLR_SKEW_BYTE)
                        begin
                            state     <= ST_SKEW;
                            bitCnt    <= 3'h0;
                            rxByteClk <= 1'b1;
                            rxSkewCal <= 1'b1;
                        end
                    end
                end
                ST_DATA:
                begin
                    if (laneStop)
                    begin
                        state    <= ST_FLUSH;
                        flushCnt <= 2'h0;
                    end
                    else if (bitStb)
                    begin
                        shiftReg  <= nextShift;
                        bitCnt    <= bitCnt + 3'h1;
                        // byte clock only while bits arrive
                        rxByteClk <= bitCnt == 3'h7 || bitCnt < 3'h3;
                        // earliest bit lands in bit 0
                        if (bitCnt == 3'h7)
                        begin
                            heldByte  <= nextShift;
                            heldValid <= 1'b1;
                        end
                        // outputs change at the falling edge
                        if (bitCnt == 3'h3)
                        begin
                            rxActive     <= 1'b1;
                            rxSyncSeen   <= startPending;
                            startPending <= 1'b0;
                            // no ready, bytes at line pace
                            rxValid      <= heldValid;
                            rxData       <= heldByte;
                            heldValid    <= 1'b0;
                            if (heldValid)
                            begin
                                burstCnt <= burstCnt + 16'h0001;
                            end
                        end
                    end
                end
                ST_SKEW:
                begin
                    if (laneStop)
                    begin
                        state     <= ST_IDLE;
                        rxByteClk <= 1'b0;
                        rxSkewCal <= 1'b0;
                    end
                    else if (bitStb)
                    begin
                        bitCnt    <= bitCnt + 3'h1;
                        rxByteClk <= bitCnt == 3'h7 || bitCnt < 3'h3;
                    end
                end
                ST_FLUSH:
                begin
                    // Last byte gets one more byte-clock cycle
                    flushCnt <= flushCnt + 2'h1;
                    case (flushCnt)
                        2'h0:
                        begin
                            rxByteClk  <= 1'b0;
                            rxSyncSeen <= 1'b0;
                            rxValid    <= heldValid;
                            rxData     <= heldByte;
                            if (heldValid)
                            begin
                                burstCnt <= burstCnt + 16'h0001;
                            end
                            heldValid <= 1'b0;
                        end
                        2'h1:
                        begin
                            rxByteClk <= 1'b1;
                        end
                        default:
                        begin
                            // drop valid and active at burst end
                            rxByteClk <= 1'b0;
                            rxValid   <= 1'b0;
                            rxActive  <= 1'b0;
                            state     <= ST_IDLE;
                        end
                    endcase
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Events
    always @*
    begin
        evNow = {`SLR_EV_WIDTH{1'b0}};
        evNow[`SLR_EV_BURST_START] = state == ST_HUNT && bitStb &&
                                     !laneStop &&
                                     nextShift == `SLR_SYNC_BYTE;
        evNow[`SLR_EV_BURST_END]   = state == ST_FLUSH &&
                                     flushCnt == 2'h2;
        evNow[`SLR_EV_ULPS_ENTRY]  = ulpsArmed && clkLp == `SLR_LP_ZERO &&
                                     clock_lane_ultra_low_power_n;
        evNow[`SLR_EV_SKEW_SEEN]   = state == ST_SKEW && laneStop;
        evNow[`SLR_EV_CLK_LOST]    = clock_lane_clock_present && !bitStb &&
                                     idleCnt == `SLR_CLK_IDLE_LAST;
    end

    ////////////////////////////////////////////////////////////////////////
    // APB read mux
    always @*
    begin
        next_prdata  = 32'h00000000;
        next_pslverr = 1'b0;
        case (paddr)
            `SLR_ADDR_CTRL:
            begin
                next_prdata[1:0] = ctrl;
            end
            `SLR_ADDR_STATUS:
            begin
                next_prdata[`SLR_ST_CLK_PRESENT] = clock_lane_clock_present;
                next_prdata[`SLR_ST_ULPS]   = !clock_lane_ultra_low_power_n;
                next_prdata[`SLR_ST_ACTIVE] = rxActive;
                next_prdata[`SLR_ST_SKEW]   = rxSkewCal;
            end
            `SLR_ADDR_INT_STAT:
            begin
                next_prdata[`SLR_EV_WIDTH-1:0] = intStat;
            end
            `SLR_ADDR_INT_EN:
            begin
                next_prdata[`SLR_EV_WIDTH-1:0] = intEn;
            end
            `SLR_ADDR_INT_CLR:
            begin
                next_prdata = 32'h00000000;
            end
            `SLR_ADDR_BYTE_CNT:
            begin
                next_prdata[15:0] = byteCnt;
            end
            default:
            begin
                next_pslverr = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave, interrupt
    always @(posedge clk)
    begin
        if (rst)
        begin
            ctrl    <= `SLR_CTRL_RESET;
            intEn   <= `SLR_INT_EN_RESET;
            intStat <= {`SLR_EV_WIDTH{1'b0}};
            byteCnt <= 16'h0000;
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            irq     <= 1'b0;
        end
        else
        begin
            pready  <= apbSetup;
            pslverr <= apbSetup & next_pslverr;
            if (apbSetup && !pwrite)
            begin
                prdata <= next_prdata;
            end
            if (apbWrite && paddr == `SLR_ADDR_CTRL)
            begin
                ctrl <= pwdata[1:0];
            end
            if (apbWrite && paddr == `SLR_ADDR_INT_EN)
            begin
                intEn <= pwdata[`SLR_EV_WIDTH-1:0];
            end
            // New events win over a simultaneous clear
            if (apbWrite && paddr == `SLR_ADDR_INT_CLR)
            begin
                intStat <= (intStat & ~pwdata[`SLR_EV_WIDTH-1:0]) | evNow;
            end
            else
            begin
                intStat <= intStat | evNow;
            end
            if (evNow[`SLR_EV_BURST_END])
            begin
                byteCnt <= burstCnt;
            end
            irq <= |(intStat & intEn);
        end
    end

endmodule

`default_nettype wire

/* verif/slr_lane_rx_assertions.sv */
/* Concurrent checks on the lane receive port outputs.
   Bound into slr_lane_rx; sees only its ports, single clock domain. */
`timescale 1ns/1ns
`default_nettype none
`include "slr_regs.vh"
module slr_lane_rx_assertions
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       laneClkPin,
    input wire logic [1:0] clkLaneLpPin,
    input wire logic       clock_lane_clock_present,
    input wire logic       clock_lane_ultra_low_power_n,
    input wire logic       rxByteClk,
    input wire logic [7:0] rxData,
    input wire logic       rxValid,
    input wire logic       rxActive,
    input wire logic       rxSyncSeen,
    input wire logic       rxSkewCal
);
    logic       prevLaneClk;
    logic [7:0] quietCnt;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Cycles since the lane clock last moved
    always @(posedge clk)
    begin
        prevLaneClk <= laneClkPin;
        if (rst || laneClkPin != prevLaneClk)
            quietCnt <= 8'h00;
        else if (quietCnt != 8'hFF)
            quietCnt <= quietCnt + 8'h01;
    end

    ////////////////////
    sequence syncStart;
        $rose(rxSyncSeen);
    endsequence
    sequence laneStopped;
        (clkLaneLpPin == `SLR_LP_STOP) [*8];
    endsequence
    sequence ulpsEntry;
        $fell(clock_lane_ultra_low_power_n);
    endsequence

    chk_setup_ready: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_clock_seen:
        assert property ($changed(laneClkPin) |-> ##[0:16]
            clock_lane_clock_present)
        else $error("clock present not raised");
    chk_clock_lost:
        assert property (quietCnt > 8'h3C |-> !clock_lane_clock_present)
        else $error("clock present with idle lane clock");
    chk_ulps_entry:
        assert property (ulpsEntry |-> clkLaneLpPin == `SLR_LP_ZERO)
        else $error("low power flag without low power state");
    chk_ulps_exit:
        assert property (laneStopped |-> clock_lane_ultra_low_power_n)
        else $error("low power flag held in Stop");
    chk_byteclk_live:
        assert property ($rose(rxByteClk) |-> clock_lane_clock_present)
        else $error("byte clock without lane clock");
    chk_rise_stable:
        assert property ($rose(rxByteClk) |-> $stable(rxData)
            && $stable(rxValid))
        else $error("byte changed at byte clock rise");
    chk_sync_start:
        assert property (syncStart |-> $rose(rxActive) && !rxValid)
        else $error("sync pulse not at burst start");
    chk_sync_width:
        assert property ($fell(rxSyncSeen) |-> $fell(rxByteClk))
        else $error("sync pulse not one byte period");
    chk_valid_active:
        assert property (rxValid |-> rxActive)
        else $error("valid outside burst");
    chk_skew_alone:
        assert property (rxSkewCal |-> !rxActive && !rxValid)
        else $error("skew flag with data burst");
endmodule

bind slr_lane_rx slr_lane_rx_assertions chk
(
    .clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .laneClkPin(laneClkPin),
    .clkLaneLpPin(clkLaneLpPin),
    .clock_lane_clock_present(clock_lane_clock_present),
    .clock_lane_ultra_low_power_n(clock_lane_ultra_low_power_n),
    .rxByteClk(rxByteClk), .rxData(rxData), .rxValid(rxValid),
    .rxActive(rxActive), .rxSyncSeen(rxSyncSeen), .rxSkewCal(rxSkewCal)
);
`default_nettype wire

/* verif/slr_lane_tx_model.sv */
/* Remote lane transmitter: drives lane clock, data bit and LP pins.
   Assumes its tasks are entered right after a rising clk edge. */
`timescale 1ns/1ns
`default_nettype none
`include "slr_regs.vh"
module slr_lane_tx_model
#(
    parameter int HALF_BIT = 3
)
(
    input  wire logic       clk,
    output var  logic       laneClkPin,
    output var  logic       laneBitPin,
    output var  logic [1:0] clkLaneLpPin,
    output var  logic [1:0] dataLaneLpPin
);
    logic sending;

    initial
    begin
        sending = 1'b0;
        laneClkPin = 1'b0;
        laneBitPin = 1'b0;
        clkLaneLpPin = `SLR_LP_STOP;
        dataLaneLpPin = `SLR_LP_STOP;
    end

    // Idle data line never holds a stale bit
    always @(posedge clk)
    begin
        if (!sending)
            laneBitPin <= ~laneBitPin;
    end

    task automatic send_byte(input logic [7:0] b);
        for (int i = 0; i < 8; i++)
        begin
            laneBitPin <= b[i];
            repeat (HALF_BIT) @(posedge clk);
            laneClkPin <= ~laneClkPin;
            repeat (HALF_BIT) @(posedge clk);
        end
    endtask

    task automatic send_burst(input logic [7:0] lead, input logic [7:0] q[$]);
        sending <= 1'b1;
        clkLaneLpPin <= 2'h1;
        repeat (8) @(posedge clk);
        clkLaneLpPin <= `SLR_LP_ZERO;
        dataLaneLpPin <= `SLR_LP_ZERO;
        repeat (8) @(posedge clk);
        send_byte(8'h00);
        send_byte(lead);
        foreach (q[i])
            send_byte(q[i]);
        repeat (4) @(posedge clk);
        // lane clock stands still outside bursts
        dataLaneLpPin <= `SLR_LP_STOP;
        clkLaneLpPin <= `SLR_LP_STOP;
        sending <= 1'b0;
        repeat (10) @(posedge clk);
    endtask

    task automatic set_ulps(input logic enter);
        if (enter)
        begin
            clkLaneLpPin <= `SLR_LP_ULPS_REQ;
            repeat (8) @(posedge clk);
            clkLaneLpPin <= `SLR_LP_ZERO;
        end
        else
            clkLaneLpPin <= `SLR_LP_STOP;
        repeat (12) @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* verif/slr_lane_rx_test.sv */
/* Self-checking bench for the lane receive port.
   Drives APB and, through the transmitter model, the lane pins. */
`timescale 1ns/1ns
`default_nettype none
`include "slr_regs.vh"
module slr_lane_rx_test;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]  paddr, rxData;
    logic [31:0] pwdata, prdata, rdv;
    logic        laneClkPin, laneBitPin, errv, skewSeen;
    logic [1:0]  clkLaneLpPin, dataLaneLpPin;
    logic        clock_lane_clock_present, clock_lane_ultra_low_power_n;
    logic        rxByteClk, rxValid, rxActive, rxSyncSeen, rxSkewCal;
    logic [7:0]  sent[$], got[$];
    int          num_errors, num_checks, cycles, syncCount;

    slr_lane_rx dut
    (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .laneClkPin(laneClkPin),
        .laneBitPin(laneBitPin), .clkLaneLpPin(clkLaneLpPin),
        .dataLaneLpPin(dataLaneLpPin),
        .clock_lane_clock_present(clock_lane_clock_present),
        .clock_lane_ultra_low_power_n(clock_lane_ultra_low_power_n),
        .rxByteClk(rxByteClk), .rxData(rxData), .rxValid(rxValid),
        .rxActive(rxActive), .rxSyncSeen(rxSyncSeen),
        .rxSkewCal(rxSkewCal), .irq(irq)
    );
    slr_lane_tx_model #(.HALF_BIT(3)) farEnd
    (
        .clk(clk), .laneClkPin(laneClkPin), .laneBitPin(laneBitPin),
        .clkLaneLpPin(clkLaneLpPin), .dataLaneLpPin(dataLaneLpPin)
    );

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Protocol side capture, no throttle
    always @(posedge rxByteClk)
    begin
        if (rxValid === 1'b1)
            got.push_back(rxData);
        if (rxSyncSeen === 1'b1)
            syncCount++;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (rxSkewCal === 1'b1)
            skewSeen = 1'b1;
        if (cycles == 20000)
        begin
            num_errors++;
            report_and_stop();
        end
    end

    ////////////////////
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] seen);
        num_checks++;
        if (seen !== exp)
        begin
            $display("BAD %s expected %h seen %h", what, exp, seen);
            num_errors++;
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    function automatic logic irq_expected(input logic [31:0] en,
                                          input logic [31:0] stat);
        return |(en & stat);
    endfunction

    task report_and_stop;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    ////////////////////
    initial
    begin
        int len;
        logic [31:0] en;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        len = $urandom(770);
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        apb(1'b0, `SLR_ADDR_INT_EN, 32'h0);
        check("int enable reset", `SLR_INT_EN_RESET, rdv);
        apb(1'b0, 8'h18, 32'h0);
        check("unmapped error", 32'h1, {31'h0, errv});
        check("unmapped data", 32'h0, rdv);
        apb(1'b1, `SLR_ADDR_CTRL, 32'h1);
        apb(1'b0, `SLR_ADDR_CTRL, 32'h0);
        check("control", 32'h1, rdv);
        $display("registers done");
        for (int i = 0; i < 4; i++)
        begin
            en = (i % 2 == 0) ? 32'h1 << `SLR_EV_BURST_END : 32'h0;
            apb(1'b1, `SLR_ADDR_INT_EN, en);
            len = (i == 0) ? 1 : 1 + $urandom % 6;
            sent.delete();
            got.delete();
            syncCount = 0;
            for (int k = 0; k < len; k++)
                sent.push_back(8'($urandom));
            farEnd.send_burst(`SLR_SYNC_BYTE, sent);
            check("byte count", len, got.size());
            foreach (sent[k])
                check("byte", sent[k], got[k]);
            check("sync pulses", 32'h1, syncCount);
            check("active after end", 32'h0, rxActive);
            check("irq", irq_expected(en, 32'h3), irq);
            apb(1'b0, `SLR_ADDR_BYTE_CNT, 32'h0);
            check("burst length", len, rdv[15:0]);
            apb(1'b1, `SLR_ADDR_INT_CLR, 32'h1F);
            apb(1'b0, `SLR_ADDR_INT_STAT, 32'h0);
            check("end cleared", 32'h0, rdv[`SLR_EV_BURST_END]);
            check("irq cleared", 32'h0, irq);
            $display("burst %0d done", i);
        end
        repeat (60) @(posedge clk);
        check("clock present", 32'h0, clock_lane_clock_present);
        apb(1'b0, `SLR_ADDR_INT_STAT, 32'h0);
        check("clock lost", 32'h1, rdv[`SLR_EV_CLK_LOST]);
        sent = {8'hFF, 8'hFF};
        for (int m = 0; m < 2; m++)
        begin
            apb(1'b1, `SLR_ADDR_CTRL, m ? 32'h3 : 32'h1);
            skewSeen = 1'b0;
            got.delete();
            farEnd.send_burst(`SLR_SKEW_BYTE, sent);
            check("skew seen", 32'(m), skewSeen);
            check("skew bytes", 32'h0, got.size());
        end
        $display("deskew done");
        farEnd.set_ulps(1'b1);
        check("ulps entered", 32'h0, clock_lane_ultra_low_power_n);
        apb(1'b0, `SLR_ADDR_STATUS, 32'h0);
        check("status ulps", 32'h1, rdv[`SLR_ST_ULPS]);
        farEnd.set_ulps(1'b0);
        check("ulps left", 32'h1, clock_lane_ultra_low_power_n);
        $display("ulps done");
        report_and_stop();
    end
endmodule
`default_nettype wire
